// ===== output_driver_pkg.sv
// package: constants and carrier types for the addressable output driver
package output_driver_pkg;

    localparam int          NUM_OUTPUTS  = 8;
    localparam int          ADDR_BITS    = 3;
    localparam logic [7:0]  LATCH_RESET  = 8'h00;
    localparam logic        BIT_ON       = 1'b1;
    localparam int          SYNC_STAGES  = 2;

    // one host write: three address bits plus the on/off bit
    typedef struct packed {
        logic [ADDR_BITS-1:0] addr;
        logic                 on;
    } write_word_t;

    // synchronised pin levels
    typedef struct packed {
        logic        chip_en_n;
        logic        clear_n;
        write_word_t word;
    } pin_set_t;

endpackage

// ===== pin_sync.sv
// module: two flip-flop synchroniser for a group of pins
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH    = 6,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sync_state_t;

    sync_state_t state_q;
    sync_state_t state_d;

    // the two stages are written out by hand; a deeper chain needs new code
    if (WIDTH < 1 || output_driver_pkg::SYNC_STAGES != 2) begin : g_bad_param
        $error("pin_sync needs a width of at least one and exactly two stages");
    end

    always_comb begin
        state_d      = state_q;
        state_d.meta = i_async;
        // first stage feeds only the second
        state_d.sync = state_q.meta;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= {RESET_VAL, RESET_VAL};
        end else begin
            state_q <= state_d;
        end
    end

    assign o_sync = state_q.sync;

endmodule

// ===== addressable_output_driver.sv
// module: eight addressable output latches with chip enable and master clear
`timescale 1ns/10ps
// Overview of operation
// - eight latches, demultiplexer routes bit to one
// - three-bit address picks one distinct latch
// - single data bit sets or resets latch
// - latches hold value until rewritten or cleared
// - writes only while low chip enable asserted
// - low master clear turns all outputs off
// - four bits per write: address plus on/off
// - sinking variant: ON drives pin low
// - global clear ignores address inputs
module addressable_output_driver #(
    parameter int NUM_OUT = output_driver_pkg::NUM_OUTPUTS,
    parameter int ADDR_W  = output_driver_pkg::ADDR_BITS
) (
    input  wire logic               i_clk,
    input  wire logic               i_rstn,
    input  wire logic               i_chip_en_n,
    input  wire logic               i_clear_n,
    input  wire logic [ADDR_W-1:0]  i_addr,
    input  wire logic               i_data_on,
    output logic      [NUM_OUT-1:0] o_latch_on,
    output logic      [NUM_OUT-1:0] o_sink_out,
    output logic      [NUM_OUT-1:0] o_sink_oe
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (NUM_OUT != (1 << ADDR_W)) begin : g_bad_count
        $error("output count must equal two to the address width");
    end
    if (NUM_OUT != output_driver_pkg::NUM_OUTPUTS) begin : g_bad_reset
        $error("output count must match the latch reset width");
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int PW = ADDR_W + 3;

    logic [PW-1:0] pins_async;
    logic [PW-1:0] pins_sync;
    output_driver_pkg::pin_set_t pins;

    assign pins_async = {i_chip_en_n, i_clear_n, i_addr, i_data_on};

    // enables idle inactive so reset release does not look like a write
    pin_sync #(
        .WIDTH     (PW),
        .RESET_VAL ({2'b11, {(PW-2){1'b0}}})
    ) u_pin_sync (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_async (pins_async),
        .o_sync  (pins_sync)
    );

    assign pins = output_driver_pkg::pin_set_t'(pins_sync);

    // ------------------------------------------------------------
    // latch state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_OUT-1:0] latch;
    } drv_state_t;

    drv_state_t state_q;
    drv_state_t state_d;

    logic [NUM_OUT-1:0] sel;
    logic               write_en;

    // writes are level controlled: while enabled, the addressed latch follows the data bit
    assign write_en = !pins.chip_en_n;

    // one-hot demultiplexer, one select line per latch
    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g++) begin : g_demux
            assign sel[g] = write_en && (pins.word.addr == ADDR_W'(g));
        end
    endgenerate

    always_comb begin
        state_d = state_q;
        if (!pins.clear_n) begin
            // clear ignores address and beats any concurrent write
            state_d.latch = output_driver_pkg::LATCH_RESET;
        end else begin
            for (int i = 0; i < NUM_OUT; i++) begin
                if (sel[i]) begin
                    state_d.latch[i] = (pins.word.on == output_driver_pkg::BIT_ON);
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q.latch <= output_driver_pkg::LATCH_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // sink pin: driven low while ON, released while OFF; data stays low, enable toggles
    assign o_latch_on = state_q.latch;
    assign o_sink_out = '0;
    assign o_sink_oe  = state_q.latch;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_clear_seen;
        !pins.clear_n;
    endsequence

    sequence s_write_seen;
        pins.clear_n && !pins.chip_en_n;
    endsequence

    sequence s_write_on;
        pins.clear_n && !pins.chip_en_n && (pins.word.on == output_driver_pkg::BIT_ON);
    endsequence

    sequence s_write_off;
        pins.clear_n && !pins.chip_en_n && (pins.word.on != output_driver_pkg::BIT_ON);
    endsequence

    property p_clear_all_off;
        @(posedge i_clk) disable iff (!i_rstn)
        s_clear_seen |=> (state_q.latch == '0);
    endproperty
    a_clear_all_off: assert property (p_clear_all_off)
        else $error("clear did not turn every latch off");

    property p_clear_beats_write;
        @(posedge i_clk) disable iff (!i_rstn)
        (!pins.clear_n && !pins.chip_en_n && pins.word.on) |=> (o_latch_on == '0);
    endproperty
    a_clear_beats_write: assert property (p_clear_beats_write)
        else $error("write survived a simultaneous clear");

    property p_write_hits_addr;
        @(posedge i_clk) disable iff (!i_rstn)
        s_write_seen |=> (o_latch_on[$past(pins.word.addr)] == $past(pins.word.on));
    endproperty
    a_write_hits_addr: assert property (p_write_hits_addr)
        else $error("addressed latch did not take the data bit");

    property p_write_one_latch;
        @(posedge i_clk) disable iff (!i_rstn)
        s_write_seen |=> $countones(o_latch_on ^ $past(o_latch_on)) <= 1;
    endproperty
    a_write_one_latch: assert property (p_write_one_latch)
        else $error("a write changed more than one latch");

    property p_hold_when_idle;
        @(posedge i_clk) disable iff (!i_rstn)
        (pins.chip_en_n && pins.clear_n) |=> $stable(o_latch_on);
    endproperty
    a_hold_when_idle: assert property (p_hold_when_idle)
        else $error("latch changed with no write or clear");

    // with the enable off a clear may still turn latches off, but nothing turns on
    property p_no_write_disabled;
        @(posedge i_clk) disable iff (!i_rstn)
        pins.chip_en_n |=> ((o_latch_on & ~$past(o_latch_on)) == '0);
    endproperty
    a_no_write_disabled: assert property (p_no_write_disabled)
        else $error("latch written while chip enable inactive");

    property p_on_bit_sets;
        @(posedge i_clk) disable iff (!i_rstn)
        (s_write_seen and (pins.word.on == 1'b1)) |=> ($countones(o_latch_on) >= 1);
    endproperty
    a_on_bit_sets: assert property (p_on_bit_sets)
        else $error("on write left every latch off");

    property p_sink_low_on;
        @(posedge i_clk) disable iff (!i_rstn)
        (o_sink_oe == o_latch_on) && (o_sink_out == '0);
    endproperty
    a_sink_low_on: assert property (p_sink_low_on)
        else $error("sink pin does not follow the latch");

    property p_off_bit_clears;
        @(posedge i_clk) disable iff (!i_rstn)
        s_write_off |=> (o_latch_on[$past(pins.word.addr)] == 1'b0);
    endproperty
    a_off_bit_clears: assert property (p_off_bit_clears)
        else $error("off write left the addressed latch on");

    property p_others_kept;
        @(posedge i_clk) disable iff (!i_rstn)
        s_write_seen |=> (((o_latch_on ^ $past(o_latch_on)) & ~$past(sel)) == '0);
    endproperty
    a_others_kept: assert property (p_others_kept)
        else $error("a write disturbed a latch it did not address");

    property p_clear_holds_off;
        @(posedge i_clk) disable iff (!i_rstn)
        s_clear_seen ##1 s_clear_seen |=> (o_sink_oe == '0);
    endproperty
    a_clear_holds_off: assert property (p_clear_holds_off)
        else $error("a sink pin stayed driven under a held clear");

    property p_write_reaches_pin;
        @(posedge i_clk) disable iff (!i_rstn)
        s_write_on |=> (o_sink_oe[$past(pins.word.addr)] == 1'b1);
    endproperty
    a_write_reaches_pin: assert property (p_write_reaches_pin)
        else $error("on write did not pull the addressed pin low");

endmodule

// ===== host_bus_model.sv
// host side model: bus writes onto the driver's pins
`timescale 1ns/10ps
module host_bus_model (
    input  wire logic       i_clk,
    output logic            o_chip_en_n,
    output logic            o_clear_n,
    output logic [2:0]      o_addr,
    output logic            o_data_on
);
    initial begin
        o_chip_en_n = 1'b1;
        o_clear_n   = 1'b1;
        o_addr      = 3'h0;
        o_data_on   = 1'b0;
    end
    // pins change at the falling edge and hold n cycles
    task automatic pins(input logic c, input logic e,
                        input output_driver_pkg::write_word_t w, input int n);
        @(negedge i_clk);
        o_clear_n           = c;
        o_chip_en_n         = e;
        {o_addr, o_data_on} = w;
        repeat (n - 1) @(negedge i_clk);
    endtask
    // address settles before the enable opens, else a passing address gets written
    task automatic write(input output_driver_pkg::write_word_t w);
        pins(1'b1, 1'b1, w, 1);
        pins(1'b1, 1'b0, w, 4);
        pins(1'b1, 1'b1, w, 1);
    endtask
endmodule

// ===== tb_addressable_output_driver.sv
// self-checking bench for the addressable output driver
`timescale 1ns/10ps
module tb_addressable_output_driver;
    logic                           clk = 1'b0;
    logic                           rst_n = 1'b0;
    logic                           chip_en_n, clear_n, data_on;
    logic [2:0]                     addr;
    logic [7:0]                     latch_on, sink_out, sink_oe, model_q;
    logic [7:0]                     exp_q[$];
    output_driver_pkg::write_word_t w;
    int                             miscompares = 0;
    int                             n_compared = 0;
    int                             cycles = 0;
    int                             seed;
    event                           settled;

    always #2.5 clk = ~clk;

    host_bus_model host_bus_model_inst (.i_clk(clk), .o_chip_en_n(chip_en_n),
        .o_clear_n(clear_n), .o_addr(addr), .o_data_on(data_on));
    addressable_output_driver addressable_output_driver_inst (.i_clk(clk), .i_rstn(rst_n),
        .i_chip_en_n(chip_en_n), .i_clear_n(clear_n), .i_addr(addr), .i_data_on(data_on),
        .o_latch_on(latch_on), .o_sink_out(sink_out), .o_sink_oe(sink_oe));

    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // wait out the three-edge pin path, then note what the host believes
    task automatic expect_state();
        repeat (4) @(negedge clk);
        exp_q.push_back(model_q);
        -> settled;
    endtask

    always @(settled) begin : watch
        logic [7:0] e;
        e = exp_q.pop_front();
        n_compared++;
        if (latch_on !== e || sink_oe !== e || sink_out !== 8'h00) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h oe %h exp %h", $time, latch_on, sink_oe, e);
        end
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        seed = $urandom(21149);
        model_q = 8'h00;
        repeat (20) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        expect_state();
        $display("test reset done");
        for (int a = 0; a < 8; a++) begin
            host_bus_model_inst.write({a[2:0], 1'b1});
            model_q[a] = 1'b1;
            expect_state();
        end
        $display("test walk on done");
        for (int k = 0; k < 24; k++) begin
            w = 4'($urandom);
            host_bus_model_inst.write(w);
            model_q[w.addr] = w.on;
            expect_state();
        end
        $display("test random writes done");
        // enable held off while address and data wander
        for (int k = 0; k < 6; k++) begin
            w = 4'($urandom);
            host_bus_model_inst.pins(1'b1, 1'b1, w, 2);
        end
        expect_state();
        $display("test enable off done");
        host_bus_model_inst.write({3'h6, 1'b1});
        model_q[6] = 1'b1;
        w = 4'($urandom);
        host_bus_model_inst.pins(1'b0, 1'b1, w, 1);
        model_q = 8'h00;
        expect_state();
        host_bus_model_inst.pins(1'b1, 1'b1, w, 1);
        $display("test clear done");
        host_bus_model_inst.pins(1'b0, 1'b0, {3'h2, 1'b1}, 1);
        expect_state();
        host_bus_model_inst.pins(1'b1, 1'b1, {3'h2, 1'b1}, 1);
        expect_state();
        $display("test clear over write done");
        wrap_up();
    end
endmodule
